// >>> hw/ude_params.svh
// constants for the user data extractor: positions, limits and sizes
// Operation
// R1: first status byte: bits 0-1 from 29,28; 2-3 from 25,24; 4-7 from 3..0.
// R2: second status byte bit n comes from channel status bit 15 minus n.
// R3: more than eight consecutive zero user bits end a message.
// R4: zero to eight zeros between units keep the message open.
// R5: units assemble first bit as MSB; that leading one is the start bit.
// R6: subcode unit reads start bit, then Q, R, S, T, U, V, W.
// R7: Q mode control buffers only Q bits, twelve bytes per subcode frame.
// R8: Q decoding applies whenever enabled, no check for a CD source.
// R9: take the user bit from each subframe and hunt for message starts.
// R10: normal mode stores each unit; zeros between units and messages dropped.
// R11: first byte of a message keeps MSB one; later bytes force it zero.
// R12: buffer is a 128 byte first-in first-out store.
// R13: normal mode: pending flag low with one byte stored, high once drained.
// R14: host must read within 17 ms, else newest bytes are dropped.
// R15: host link shifts each byte LSB first: W..Q, then start bit.
// R16: Q mode packs eight Q bits per byte, earliest in the MSB.
// R17: Q mode: pending flag low while twelve or more bytes are stored.
// R18: writes stop when full, resume with one free byte; overrun flagged.
// R19: Q frame byte goes out on the link Q8 first, Q1 last.
// R20: channel status comes only from block start and left subframes.
`ifndef UDE_PARAMS_SVH
`define UDE_PARAMS_SVH

`define UDE_CS_LEN        30
`define UDE_CS_LAST       29
`define UDE_CS_CLK_ACC_0  29
`define UDE_CS_CLK_ACC_1  28
`define UDE_CS_FS_0       25
`define UDE_CS_FS_1       24
`define UDE_CS_EMPH       3
`define UDE_CS_COPY       2
`define UDE_CS_AUDIO      1
`define UDE_CS_PRO        0
`define UDE_CS_CAT_TOP    15
`define UDE_UNIT_BITS     8
`define UDE_GAP_MAX       8
`define UDE_Q_BIT_POS     1
`define UDE_Q_FRAME_BYTES 12
`define UDE_FIFO_DEPTH    128
`define UDE_RESET_BYTE    8'h00

`endif

// >>> hw/ude_pkg.sv
// types shared by the user data extractor files
package ude_pkg;

    typedef enum logic [1:0]
    {
        UDE_PRE_BLOCK = 2'b00,
        UDE_PRE_LEFT  = 2'b01,
        UDE_PRE_RIGHT = 2'b10
    } ude_pre_t;

    typedef enum logic [1:0]
    {
        UDE_PS_HUNT = 2'b00,
        UDE_PS_UNIT = 2'b01,
        UDE_PS_GAP  = 2'b10
    } ude_parse_t;

endpackage : ude_pkg

// >>> hw/ude_link_tx.sv
// link clock side: serialises handed-over bytes lsb first to the host
`timescale 1ns/1ps
`include "ude_params.svh"
module ude_link_tx
(
    // link clock and system reset
    input  wire logic       link_clk_in,
    input  wire logic       sys_rst_in,
    // host select, same domain as the link clock
    input  wire logic       select_in,
    // byte handover from the system domain
    input  wire logic       req_tgl_in,
    input  wire logic [7:0] byte_in,
    output logic            ack_tgl_out,
    // serial data pin
    output logic            data_out,
    output logic            data_oe_out
);
    logic       rst_meta_q;
    logic       rst_q;
    logic       req_meta_q;
    logic       req_sync_q;
    logic       ack_q;
    logic [2:0] bit_cnt_q;
    logic [6:0] shift_q;
    logic       data_q;
    logic       oe_q;
    wire        new_byte;
    wire        load;

    assign new_byte    = req_sync_q ^ ack_q;
    assign load        = select_in && (bit_cnt_q == 3'd0);
    assign ack_tgl_out = ack_q;
    assign data_out    = data_q;
    assign data_oe_out = oe_q;

    // the link clock may stop between transfers, so reset is only seen on edges
    always_ff @(posedge link_clk_in)
    begin
        rst_meta_q <= sys_rst_in;
        rst_q      <= rst_meta_q;
        req_meta_q <= req_tgl_in;
        req_sync_q <= req_meta_q;
    end

    // with nothing handed over, zeros are clocked out
    always_ff @(posedge link_clk_in)
    begin
        if (rst_q)
        begin
            ack_q     <= 1'b0;
            bit_cnt_q <= 3'd0;
            shift_q   <= 7'h00;
            data_q    <= 1'b0;
            oe_q      <= 1'b0;
        end
        else
        begin
            oe_q <= select_in;
            if (!select_in)
                bit_cnt_q <= 3'd0;
            else
                bit_cnt_q <= bit_cnt_q + 3'd1;
            if (load)
            begin
                data_q  <= new_byte ? byte_in[0] : 1'b0;     // R15 R19
                shift_q <= new_byte ? byte_in[7:1] : 7'h00;
                if (new_byte)
                    ack_q <= req_sync_q;
            end
            else if (select_in)
            begin
                data_q  <= shift_q[0];                        // R15
                shift_q <= {1'b0, shift_q[6:1]};
            end
        end
    end
endmodule : ude_link_tx

// >>> hw/ude_extractor.sv
// user data extractor: status byte mapping, message parser, byte fifo, host handover
`timescale 1ns/1ps
`include "ude_params.svh"
module ude_extractor
#(
    parameter int FIFO_DEPTH  = `UDE_FIFO_DEPTH,
    parameter int FRAME_BYTES = `UDE_Q_FRAME_BYTES
)
(
    // system clock and reset
    input  wire logic             CLK_IN,
    input  wire logic             SRST_IN,
    // subframe stream from the biphase decoder
    input  wire logic             SUB_VALID_IN,
    input  wire ude_pkg::ude_pre_t SUB_PREAMBLE_IN,
    input  wire logic             SUB_USER_IN,
    input  wire logic             SUB_CS_IN,
    // control from the host control logic
    input  wire logic             Q_MODE_IN,
    input  wire logic             BUF_CLEAR_IN,
    // channel status bytes
    output logic [7:0]            CS_BYTE0_OUT,
    output logic [7:0]            CS_BYTE1_OUT,
    output logic                  CS_UPDATE_OUT,
    // buffer state
    output logic                  USER_BYTES_PENDING_N_OUT,
    output logic                  OVERRUN_OUT,
    // host serial link
    input  wire logic             LINK_CLK_IN,
    input  wire logic             LINK_SELECT_IN,
    output logic                  LINK_DATA_OUT,
    output logic                  LINK_DATA_OE_OUT
);
    import ude_pkg::*;

    localparam int AW = $clog2(FIFO_DEPTH);

    initial
    begin
        if (FIFO_DEPTH < FRAME_BYTES || (1 << AW) != FIFO_DEPTH)
            $error("fifo depth must be a power of two of at least one frame");
        if (FRAME_BYTES < 1)
            $error("frame bytes must be positive");
    end

    // ---------------- channel status ----------------
    logic [`UDE_CS_LEN-1:0] cs_q;
    logic [4:0]             cs_idx_q;
    logic                   cs_done_q;
    logic [7:0]             cs0_q;
    logic [7:0]             cs1_q;
    wire                    left_sub;
    wire                    block_start;
    wire [4:0]              cap_idx;
    wire                    cap_ok;
    wire [7:0]              cs0_map;
    wire [7:0]              cs1_map;

    assign left_sub    = SUB_VALID_IN && (SUB_PREAMBLE_IN == UDE_PRE_BLOCK
                                          || SUB_PREAMBLE_IN == UDE_PRE_LEFT);   // R20
    assign block_start = SUB_VALID_IN && SUB_PREAMBLE_IN == UDE_PRE_BLOCK;
    assign cap_idx     = block_start ? 5'd0 : cs_idx_q;
    assign cap_ok      = left_sub && (cap_idx < 5'(`UDE_CS_LEN));

    assign cs0_map = {cs_q[`UDE_CS_PRO], cs_q[`UDE_CS_AUDIO], cs_q[`UDE_CS_COPY],
                      cs_q[`UDE_CS_EMPH], cs_q[`UDE_CS_FS_1], cs_q[`UDE_CS_FS_0],
                      cs_q[`UDE_CS_CLK_ACC_1], cs_q[`UDE_CS_CLK_ACC_0]};          // R1

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_cat
            assign cs1_map[gi] = cs_q[`UDE_CS_CAT_TOP - gi];                    // R2
        end
    endgenerate

    // bytes only update after a whole block, so software never sees a torn mix
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            cs_q      <= '0;
            cs_idx_q  <= 5'(`UDE_CS_LEN);
            cs_done_q <= 1'b0;
            cs0_q     <= `UDE_RESET_BYTE;
            cs1_q     <= `UDE_RESET_BYTE;
        end
        else
        begin
            cs_done_q <= cap_ok && cap_idx == 5'(`UDE_CS_LAST);
            if (cap_ok)
            begin
                cs_q[cap_idx] <= SUB_CS_IN;                                     // R20
                cs_idx_q      <= cap_idx + 5'd1;
            end
            if (cs_done_q)
            begin
                cs0_q <= cs0_map;
                cs1_q <= cs1_map;
            end
        end
    end

    assign CS_BYTE0_OUT  = cs0_q;
    assign CS_BYTE1_OUT  = cs1_q;
    assign CS_UPDATE_OUT = cs_done_q;

    // ---------------- user data parser ----------------
    ude_parse_t ps_q;
    ude_parse_t ps_d;
    logic [6:0] unit_q;
    logic [2:0] bit_cnt_q;
    logic [3:0] zero_cnt_q;
    logic       first_q;
    logic [6:0] q_acc_q;
    logic [2:0] q_cnt_q;
    wire        ubit;
    wire        ustep;
    wire        unit_end;
    wire        q_take;
    wire        q_full;
    wire        gap_over;
    wire        wr_en;
    wire [7:0]  wr_data;
    wire [7:0]  unit_byte;

    assign ustep     = SUB_VALID_IN;                                            // R9
    assign ubit      = SUB_USER_IN;
    assign unit_end  = ustep && ps_q == UDE_PS_UNIT && bit_cnt_q == 3'(`UDE_UNIT_BITS - 1);
    assign q_take    = ustep && ps_q == UDE_PS_UNIT && bit_cnt_q == 3'(`UDE_Q_BIT_POS)
                       && Q_MODE_IN;                                            // R6 R7 R8
    assign q_full    = q_take && q_cnt_q == 3'd7;
    assign gap_over  = ustep && ps_q == UDE_PS_GAP && !ubit
                       && zero_cnt_q == 4'(`UDE_GAP_MAX);                       // R3
    assign unit_byte = {first_q & unit_q[6], unit_q[5:0], ubit};                // R5 R11
    assign wr_en     = Q_MODE_IN ? q_full : unit_end;                           // R10
    assign wr_data   = Q_MODE_IN ? {q_acc_q, ubit} : unit_byte;                 // R16

    always_comb
    begin
        ps_d = ps_q;
        if (ustep)
        begin
            unique case (ps_q)
                UDE_PS_HUNT:
                    if (ubit)
                        ps_d = UDE_PS_UNIT;                                     // R5
                UDE_PS_UNIT:
                    if (bit_cnt_q == 3'(`UDE_UNIT_BITS - 1))
                        ps_d = UDE_PS_GAP;
                UDE_PS_GAP:
                    if (ubit)
                        ps_d = UDE_PS_UNIT;                                     // R4
                    else if (gap_over)
                        ps_d = UDE_PS_HUNT;                                     // R3
                default:
                    ps_d = UDE_PS_HUNT;
            endcase
        end
    end

    // zeros outside units only move counters, never reach the buffer
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            ps_q       <= UDE_PS_HUNT;
            unit_q     <= 7'h00;
            bit_cnt_q  <= 3'd0;
            zero_cnt_q <= 4'd0;
            first_q    <= 1'b1;
        end
        else
        begin
            ps_q <= ps_d;
            if (ustep)
            begin
                if (ps_q != UDE_PS_UNIT && ubit)
                begin
                    unit_q    <= 7'h01;                                         // R5
                    bit_cnt_q <= 3'd1;
                end
                else if (ps_q == UDE_PS_UNIT)
                begin
                    unit_q    <= {unit_q[5:0], ubit};
                    bit_cnt_q <= bit_cnt_q + 3'd1;
                end
                if (ps_q == UDE_PS_GAP && !ubit)
                    zero_cnt_q <= zero_cnt_q + 4'd1;                            // R10
                else
                    zero_cnt_q <= 4'd0;
                if (unit_end)
                    first_q <= 1'b0;                                            // R11
                else if (gap_over)
                    first_q <= 1'b1;
            end
        end
    end

    // q packing survives message gaps; a buffer clear restarts byte alignment
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN || BUF_CLEAR_IN)
        begin
            q_acc_q <= 7'h00;
            q_cnt_q <= 3'd0;
        end
        else if (q_take)
        begin
            q_acc_q <= {q_acc_q[5:0], ubit};                                    // R16
            q_cnt_q <= q_cnt_q + 3'd1;
        end
    end

    // ---------------- byte fifo ----------------
    logic [7:0]  mem_q [0:FIFO_DEPTH-1];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [AW:0]   cnt_q;
    logic          ovr_q;
    logic          pend_n_q;
    logic [7:0]    hold_q;
    logic          req_q;
    logic          ack_meta_q;
    logic          ack_sync_q;
    wire           full;
    wire           empty;
    wire           push;
    wire           pop;
    wire           hold_busy;
    wire [AW+1:0]  stored;
    wire           avail;
    wire           link_ack;

    assign full      = cnt_q == (AW+1)'(FIFO_DEPTH);                            // R12
    assign empty     = cnt_q == '0;
    assign push      = wr_en && !full && !BUF_CLEAR_IN;                         // R18 R14
    assign hold_busy = req_q ^ ack_sync_q;
    assign pop       = !hold_busy && !empty && !BUF_CLEAR_IN;
    assign stored    = {1'b0, cnt_q} + (AW+2)'(hold_busy);
    assign avail     = Q_MODE_IN ? (stored >= (AW+2)'(FRAME_BYTES))             // R17
                                 : (stored != '0);                              // R13

    always_ff @(posedge CLK_IN)
    begin
        if (push)
            mem_q[wr_ptr_q] <= wr_data;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN || BUF_CLEAR_IN)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_q <= wr_ptr_q + AW'(1);
            if (pop)
                rd_ptr_q <= rd_ptr_q + AW'(1);
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // an overrun in the same cycle as a clear still leaves the flag set
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            ovr_q    <= 1'b0;
            pend_n_q <= 1'b1;
        end
        else
        begin
            ovr_q    <= (ovr_q && !BUF_CLEAR_IN) || (wr_en && full);            // R18
            pend_n_q <= !avail;                                                 // R13 R17
        end
    end

    assign OVERRUN_OUT              = ovr_q;
    assign USER_BYTES_PENDING_N_OUT = pend_n_q;

    // ---------------- handover to the link clock ----------------
    // the hold byte stays stable until the link side echoes the toggle back
    always_ff @(posedge CLK_IN)
    begin
        ack_meta_q <= link_ack;
        ack_sync_q <= ack_meta_q;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
        begin
            hold_q <= `UDE_RESET_BYTE;
            req_q  <= 1'b0;
        end
        else if (pop)
        begin
            hold_q <= mem_q[rd_ptr_q];
            req_q  <= !req_q;
        end
    end

    ude_link_tx u_link
    (
        .link_clk_in (LINK_CLK_IN),
        .sys_rst_in  (SRST_IN),
        .select_in   (LINK_SELECT_IN),
        .req_tgl_in  (req_q),
        .byte_in     (hold_q),
        .ack_tgl_out (link_ack),
        .data_out    (LINK_DATA_OUT),
        .data_oe_out (LINK_DATA_OE_OUT)
    );
endmodule : ude_extractor

// >>> sim/ude_extractor_checker.sv
// port assertions for the user data extractor
`timescale 1ns/1ps
module ude_extractor_checker
(
    // system side
    input  wire logic              CLK_IN,
    input  wire logic              SRST_IN,
    input  wire logic              SUB_VALID_IN,
    input  wire ude_pkg::ude_pre_t SUB_PREAMBLE_IN,
    input  wire logic              BUF_CLEAR_IN,
    input  wire logic [7:0]        CS_BYTE0_OUT,
    input  wire logic [7:0]        CS_BYTE1_OUT,
    input  wire logic              CS_UPDATE_OUT,
    input  wire logic              USER_BYTES_PENDING_N_OUT,
    input  wire logic              OVERRUN_OUT,
    // link side
    input  wire logic              LINK_CLK_IN,
    input  wire logic              LINK_SELECT_IN,
    input  wire logic              LINK_DATA_OE_OUT
);
    import ude_pkg::*;
    sequence s_rel;
        $past(SRST_IN) && !SRST_IN;
    endsequence
    property p_rst;
        @(posedge CLK_IN) disable iff (SRST_IN)
        s_rel |-> USER_BYTES_PENDING_N_OUT && !OVERRUN_OUT && !CS_UPDATE_OUT;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_cs_pulse;
        @(posedge CLK_IN) disable iff (SRST_IN) CS_UPDATE_OUT |=> !CS_UPDATE_OUT;
    endproperty
    a_cs_pulse: assert property (p_cs_pulse) else $error("status update longer than one cycle");
    // a reset edge may also clear the bytes
    property p_cs_hold;
        @(posedge CLK_IN) disable iff (SRST_IN)
        !$stable({CS_BYTE0_OUT, CS_BYTE1_OUT}) |-> $past(CS_UPDATE_OUT) || $past(SRST_IN);
    endproperty
    a_cs_hold: assert property (p_cs_hold) else $error("status bytes moved without update");
    property p_cs_src;
        @(posedge CLK_IN) disable iff (SRST_IN)
        CS_UPDATE_OUT |-> $past(SUB_VALID_IN) && $past(SUB_PREAMBLE_IN) != UDE_PRE_RIGHT;
    endproperty
    a_cs_src: assert property (p_cs_src) else $error("status update not after a left subframe");
    property p_ovr_hold;
        @(posedge CLK_IN) disable iff (SRST_IN) OVERRUN_OUT && !BUF_CLEAR_IN |=> OVERRUN_OUT;
    endproperty
    a_ovr_hold: assert property (p_ovr_hold) else $error("overrun flag dropped");
    property p_ovr_full;
        @(posedge CLK_IN) disable iff (SRST_IN) $rose(OVERRUN_OUT) |-> !USER_BYTES_PENDING_N_OUT;
    endproperty
    a_ovr_full: assert property (p_ovr_full) else $error("overrun with data flag idle");
    property p_oe_on;
        @(posedge LINK_CLK_IN) disable iff (SRST_IN) $rose(LINK_SELECT_IN) |=> LINK_DATA_OE_OUT;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("link pin not driven after select");
    property p_oe_off;
        @(posedge LINK_CLK_IN) disable iff (SRST_IN) !LINK_SELECT_IN |=> !LINK_DATA_OE_OUT;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("link pin driven while deselected");
endmodule : ude_extractor_checker

// >>> sim/ude_host_model.sv
// host model: clocks the serial link and gathers bytes lsb first
`timescale 1ns/1ps
module ude_host_model
(
    // link pins
    input  wire logic       data_in,
    output logic            link_clk_out,
    output logic            select_out,
    // collected bytes
    output logic [7:0]      byte_out,
    output logic            byte_stb_out
);
    initial
    begin
        link_clk_out = 1'b0;
        select_out   = 1'b0;
        byte_out     = 8'h00;
        byte_stb_out = 1'b0;
    end
    // the clock stands still between frames
    task automatic tick();
        #7.5 link_clk_out = 1'b1;
        #7.5 link_clk_out = 1'b0;
    endtask : tick
    // idle clocks first let the handover reach the link side
    task automatic read(input int n);
        repeat (3) tick();
        select_out = 1'b1;
        for (int i = 0; i < n; i++)
        begin
            for (int b = 0; b < 8; b++)
            begin
                tick();
                byte_out[b] = data_in;
            end
            byte_stb_out = 1'b1;
            #1 byte_stb_out = 1'b0;
        end
        select_out = 1'b0;
    endtask : read
endmodule : ude_host_model

// >>> sim/ude_extractor_tb.sv
// testbench: subframes in, status bytes and link bytes checked
`timescale 1ns/1ps
module ude_extractor_tb;
    import ude_pkg::*;
    localparam int DEPTH = 16;
    logic       clk_in = 1'b0;
    logic       srst, sub_valid, sub_user, sub_cs, q_mode, buf_clear;
    ude_pre_t   sub_pre;
    logic [7:0] cs0, cs1, host_byte, qacc;
    logic       cs_upd, pend_n, ovr, link_clk, link_sel, link_data, link_oe, host_stb;
    logic [7:0] exp_q[$];
    logic [15:0] cs_q[$];
    int         errors, cmp_count, qcnt;
    bit         lr;
    always #4 clk_in = !clk_in;
    ude_extractor #(.FIFO_DEPTH(DEPTH)) u_dut
    (
        .CLK_IN(clk_in), .SRST_IN(srst), .SUB_VALID_IN(sub_valid), .SUB_PREAMBLE_IN(sub_pre),
        .SUB_USER_IN(sub_user), .SUB_CS_IN(sub_cs), .Q_MODE_IN(q_mode), .BUF_CLEAR_IN(buf_clear),
        .CS_BYTE0_OUT(cs0), .CS_BYTE1_OUT(cs1), .CS_UPDATE_OUT(cs_upd),
        .USER_BYTES_PENDING_N_OUT(pend_n), .OVERRUN_OUT(ovr), .LINK_CLK_IN(link_clk),
        .LINK_SELECT_IN(link_sel), .LINK_DATA_OUT(link_data), .LINK_DATA_OE_OUT(link_oe)
    );
    ude_host_model u_host
    (
        .data_in(link_data), .link_clk_out(link_clk), .select_out(link_sel),
        .byte_out(host_byte), .byte_stb_out(host_stb)
    );
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    task automatic sub(input logic u, input logic c, input ude_pre_t p);
        @(negedge clk_in);
        sub_valid = 1'b1;
        sub_pre   = p;
        sub_user  = u;
        sub_cs    = c;
    endtask : sub
    task automatic settle();
        @(negedge clk_in);
        sub_valid = 1'b0;
        repeat (6) @(negedge clk_in);
    endtask : settle
    task automatic bits(input logic [7:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
        begin
            sub(v[i], 1'($urandom), lr ? UDE_PRE_RIGHT : UDE_PRE_LEFT);
            lr = !lr;
        end
    endtask : bits
    // right subframes carry the inverse so a wrong source shows up
    task automatic cs_block();
        logic [29:0] c;
        logic [7:0]  m1;
        c = 30'($urandom);
        for (int n = 0; n < 8; n++)
            m1[n] = c[15 - n];
        cs_q.push_back({c[0], c[1], c[2], c[3], c[24], c[25], c[28], c[29], m1});
        sub(1'b0, c[0], UDE_PRE_BLOCK);
        for (int i = 1; i < 30; i++)
        begin
            sub(1'b0, !c[i], UDE_PRE_RIGHT);
            sub(1'b0, c[i], UDE_PRE_LEFT);
        end
        sub(1'b0, 1'b1, UDE_PRE_RIGHT);
    endtask : cs_block
    task automatic message(input int n);
        logic [7:0] u;
        for (int i = 0; i < n; i++)
        begin
            u = {1'b1, 7'($urandom)};
            if (q_mode)
            begin
                qacc = {qacc[6:0], u[6]};
                qcnt++;
                if (qcnt % 8 == 0)
                    exp_q.push_back(qacc);
            end
            else
                exp_q.push_back(i == 0 ? u : {1'b0, u[6:0]});
            bits(u, 8);
            bits(8'h00, i == n - 1 ? 8 : $urandom_range(8));
        end
        bits(8'h00, 1);
        settle();
    endtask : message
    task automatic mode(input logic q);
        @(negedge clk_in);
        q_mode    = q;
        buf_clear = 1'b1;
        qcnt      = 0;
        @(negedge clk_in);
        buf_clear = 1'b0;
    endtask : mode
    always @(negedge clk_in)
        if (cs_upd === 1'b1)
        begin
            @(negedge clk_in);
            check("cs bytes", {cs0, cs1}, cs_q.pop_front());
        end
    always @(posedge host_stb)
        check("link byte", {8'h00, host_byte}, {8'h00, exp_q.pop_front()});
    initial
    begin
        #200_000;
        errors++;
        finish_test();
    end
    initial
    begin
        srst = 1'b1;
        sub_valid = 1'b0;
        sub_pre = UDE_PRE_LEFT;
        sub_user = 1'b0;
        sub_cs = 1'b0;
        q_mode = 1'b0;
        buf_clear = 1'b0;
        void'($urandom(32'hf92b));
        // link side resets through a synchroniser, so it needs its own edges
        fork
            repeat (8) u_host.tick();
        join_none
        repeat (4) @(negedge clk_in);
        srst = 1'b0;
        repeat (2) cs_block();
        message(3);
        message(2);
        check("pending", pend_n, 1'b0);
        repeat (5) u_host.read(1);
        settle();
        check("pending", pend_n, 1'b1);
        mode(1'b1);
        message(88);
        check("pending", pend_n, 1'b1);
        message(8);
        check("pending", pend_n, 1'b0);
        u_host.read(12);
        settle();
        check("pending", pend_n, 1'b1);
        mode(1'b0);
        message(DEPTH + 3);
        repeat (2) void'(exp_q.pop_back());
        check("overrun", ovr, 1'b1);
        repeat (DEPTH + 1) u_host.read(1);
        message(1);
        u_host.read(1);
        settle();
        check("pending", pend_n, 1'b1);
        check("overrun", ovr, 1'b1);
        mode(1'b0);
        @(negedge clk_in);
        check("overrun", ovr, 1'b0);
        finish_test();
    end
endmodule : ude_extractor_tb
bind ude_extractor ude_extractor_checker u_chk
(
    .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .SUB_VALID_IN(SUB_VALID_IN), .SUB_PREAMBLE_IN(SUB_PREAMBLE_IN),
    .BUF_CLEAR_IN(BUF_CLEAR_IN),
    .CS_BYTE0_OUT(CS_BYTE0_OUT), .CS_BYTE1_OUT(CS_BYTE1_OUT), .CS_UPDATE_OUT(CS_UPDATE_OUT),
    .USER_BYTES_PENDING_N_OUT(USER_BYTES_PENDING_N_OUT), .OVERRUN_OUT(OVERRUN_OUT),
    .LINK_CLK_IN(LINK_CLK_IN), .LINK_SELECT_IN(LINK_SELECT_IN), .LINK_DATA_OE_OUT(LINK_DATA_OE_OUT)
);
